// file: rtl/can_message_object_handler.v
`timescale 1ns/1ps
`include "can_msg_regs.vh"

module can_message_object_handler (
  input wire clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg init_hold,
  output reg [1:0] transfer_in_progress_flag,
  input wire core_tx_ready,
  output reg tx_load,
  output reg [28:0] tx_id,
  output reg tx_xtd,
  output reg tx_rtr,
  output reg [3:0] tx_dlc,
  output reg [63:0] tx_data,
  input wire core_tx_ok,
  input wire core_tx_fail,
  input wire rx_hdr,
  input wire [28:0] rx_id,
  input wire rx_xtd,
  input wire rx_rtr,
  input wire [3:0] rx_dlc,
  input wire rx_ok,
  input wire [63:0] rx_data
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_IF_RD = 2'd1;
  localparam [1:0] ST_IF_WR = 2'd2;

  // Message RAM: configuration and data, never reset
  reg [30:0] mo_arb [0:31];
  reg [30:0] mo_msk [0:31];
  reg [15:0] mo_ctl [0:31];
  reg [31:0] mo_da [0:31];
  reg [31:0] mo_db [0:31];

  // Flags kept apart so a controller reset can clear them
  reg [31:0] object_valid_flag;
  reg [31:0] new_data_flag;
  reg [31:0] interrupt_pending_flag;
  reg [31:0] transmit_request_flag;

  reg no_auto_retransmit_bit;
  reg [7:0] if_cmask [0:1];
  reg [4:0] if_num [0:1];
  reg [31:0] if_arb [0:1];
  reg [31:0] if_msk [0:1];
  reg [31:0] if_ctl [0:1];
  reg [31:0] if_da [0:1];
  reg [31:0] if_db [0:1];

  reg [1:0] state;
  reg cur;
  reg tx_active;
  reg [4:0] tx_obj;

  reg [28:0] h_id;
  reg h_xtd;
  reg h_rtr;
  reg [3:0] h_dlc;
  reg [63:0] h_data;
  reg scan_run;
  reg [4:0] scan_idx;
  reg hit;
  reg [4:0] hit_obj;
  reg rx_pend;

  reg ram_we;
  reg [4:0] ram_idx;
  reg [30:0] ram_arb;
  reg [30:0] ram_msk;
  reg [15:0] ram_ctl;
  reg [31:0] ram_da;
  reg [31:0] ram_db;

  integer i;

  function [5:0] first_set;
    input [31:0] v;
    integer k;
    begin
      first_set = `NONE_FOUND;
      for (k = 31; k >= 0; k = k - 1) begin
        if (v[k])
          first_set = {1'b0, k[4:0]};
      end
    end
  endfunction

  // Returns 1 plus set number on an interface-set address, else 0
  function [1:0] if_sel;
    input [7:0] a;
    begin
      if (a[7:4] == `IF0_HI)
        if_sel = 2'd1;
      else if (a[7:4] == `IF1_HI)
        if_sel = 2'd2;
      else
        if_sel = 2'd0;
    end
  endfunction

  function obj_match;
    input [4:0] n;
    reg um;
    reg [28:0] m;
    reg xtd_ok;
    reg dir_ok;
    reg locked;
    begin
      um = mo_ctl[n][`CT_UM];
      m = um ? mo_msk[n][28:0] : `ALL_ID_MASK;
      if (!h_xtd)
        m = m & `STD_ID_MASK;
      xtd_ok = (um && !mo_msk[n][`MK_MXTD]) || (mo_arb[n][`AR_XTD] == h_xtd);
      dir_ok = (um && !mo_msk[n][`MK_MDIR]) || (mo_arb[n][`AR_DIR] == h_rtr);
      // A filled object that is not the end of its block stays locked against data frames
      locked = !h_rtr && !mo_ctl[n][`CT_EOB] && new_data_flag[n];
      obj_match = object_valid_flag[n] && (((mo_arb[n][28:0] ^ h_id) & m) == 29'h0)
        && xtd_ok && dir_ok && !locked;
    end
  endfunction

  wire [5:0] tx_pick = first_set(object_valid_flag & transmit_request_flag);
  wire [5:0] ip_first = first_set(interrupt_pending_flag);
  wire [5:0] int_id = ip_first[5] ? 6'h0 : ip_first + 6'h1;
  wire [1:0] wsel = if_sel(addr);
  wire [1:0] rsel = if_sel(addr);
  wire [7:0] cm = if_cmask[cur];
  wire [4:0] on = if_num[cur];
  wire wdir = cm[`CM_WR];
  wire idle_free = (state == ST_IDLE) && (transfer_in_progress_flag == 2'b00);
  wire rx_apply = idle_free && rx_pend && !scan_run && hit && !init_hold;
  wire hit_dir = mo_arb[hit_obj][`AR_DIR];
  wire hit_rmt = mo_ctl[hit_obj][`CT_RMT];
  wire hit_um = mo_ctl[hit_obj][`CT_UM];
  wire tx_start = idle_free && !rx_apply && !tx_active && core_tx_ready
    && !init_hold && !tx_pick[5];

  // Single write port into the object RAM
  always @* begin
    ram_we = 1'b0;
    ram_idx = on;
    ram_arb = if_arb[cur][30:0];
    ram_msk = if_msk[cur][30:0];
    ram_ctl = if_ctl[cur][15:0];
    ram_da = if_da[cur];
    ram_db = if_db[cur];
    if (state == ST_IF_WR) begin
      ram_we = 1'b1;
    end else if (rx_apply) begin
      ram_idx = hit_obj;
      ram_arb = {mo_arb[hit_obj][`AR_DIR], h_xtd, h_id};
      ram_msk = mo_msk[hit_obj];
      ram_ctl = mo_ctl[hit_obj];
      ram_ctl[3:0] = h_dlc;
      ram_da = mo_da[hit_obj];
      ram_db = mo_db[hit_obj];
      if (!h_rtr) begin
        ram_we = 1'b1;
        ram_ctl[`CT_ML] = mo_ctl[hit_obj][`CT_ML] | new_data_flag[hit_obj];
        ram_da = h_data[31:0];
        ram_db = h_data[63:32];
      end else if (hit_dir && !hit_rmt && hit_um) begin
        ram_we = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (ram_we) begin
      mo_arb[ram_idx] <= ram_arb;
      mo_msk[ram_idx] <= ram_msk;
      mo_ctl[ram_idx] <= ram_ctl;
      mo_da[ram_idx] <= ram_da;
      mo_db[ram_idx] <= ram_db;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
      init_hold <= 1'b1;
      no_auto_retransmit_bit <= 1'b0;
      transfer_in_progress_flag <= 2'b00;
      object_valid_flag <= 32'h0;
      new_data_flag <= 32'h0;
      interrupt_pending_flag <= 32'h0;
      transmit_request_flag <= 32'h0;
      for (i = 0; i < 2; i = i + 1) begin
        if_cmask[i] <= 8'h0;
        if_num[i] <= 5'h0;
        if_arb[i] <= 32'h0;
        if_msk[i] <= 32'h0;
        if_ctl[i] <= 32'h0;
        if_da[i] <= 32'h0;
        if_db[i] <= 32'h0;
      end
      state <= ST_IDLE;
      cur <= 1'b0;
      tx_active <= 1'b0;
      tx_obj <= 5'h0;
      tx_load <= 1'b0;
      tx_id <= 29'h0;
      tx_xtd <= 1'b0;
      tx_rtr <= 1'b0;
      tx_dlc <= 4'h0;
      tx_data <= 64'h0;
      h_id <= 29'h0;
      h_xtd <= 1'b0;
      h_rtr <= 1'b0;
      h_dlc <= 4'h0;
      h_data <= 64'h0;
      scan_run <= 1'b0;
      scan_idx <= 5'h0;
      hit <= 1'b0;
      hit_obj <= 5'h0;
      rx_pend <= 1'b0;
    end else begin
      tx_load <= 1'b0;

      // Register reads, data one cycle after the strobe
      if (rd) begin
        rdata <= 32'h0;
        if (rsel != 2'd0) begin
          case (addr[3:0])
            `O_CMASK: rdata <= {24'h0, if_cmask[rsel[1]]};
            `O_CREQ: rdata <= {16'h0, transfer_in_progress_flag[rsel[1]], 9'h0,
              {1'b0, if_num[rsel[1]]} + 6'h1};
            `O_ARB: rdata <= if_arb[rsel[1]];
            `O_MSK: rdata <= if_msk[rsel[1]];
            `O_CTL: rdata <= if_ctl[rsel[1]];
            `O_DA: rdata <= if_da[rsel[1]];
            `O_DB: rdata <= if_db[rsel[1]];
            default: rdata <= 32'h0;
          endcase
        end else begin
          case (addr)
            `A_CTRL: rdata <= {30'h0, no_auto_retransmit_bit, init_hold};
            `A_TXRQ: rdata <= transmit_request_flag;
            `A_NEWDAT: rdata <= new_data_flag;
            `A_INTERRUPT_PENDING_FLAG: rdata <= interrupt_pending_flag;
            `A_VALID: rdata <= object_valid_flag;
            `A_INTID: rdata <= {26'h0, int_id};
            default: rdata <= 32'h0;
          endcase
        end
      end

      // Register writes
      if (wr) begin
        if (addr == `A_CTRL) begin
          init_hold <= wdata[`CR_INIT];
          no_auto_retransmit_bit <= wdata[`CR_DAR];
        end
        if (wsel != 2'd0) begin
          case (addr[3:0])
            `O_CMASK: if_cmask[wsel[1]] <= wdata[7:0];
            `O_CREQ: begin
              if (wdata[5:0] != 6'h0 && wdata[5:0] <= `CQ_MAXNUM) begin
                if_num[wsel[1]] <= wdata[4:0] - 5'h1;
                transfer_in_progress_flag[wsel[1]] <= 1'b1;
              end
            end
            `O_ARB: if_arb[wsel[1]] <= wdata;
            `O_MSK: if_msk[wsel[1]] <= wdata;
            `O_CTL: if_ctl[wsel[1]] <= wdata;
            `O_DA: if_da[wsel[1]] <= wdata;
            `O_DB: if_db[wsel[1]] <= wdata;
            default: ;
          endcase
        end
      end

      // Acceptance scan, one object per cycle from object 1
      if (rx_hdr && !init_hold) begin
        h_id <= rx_id;
        h_xtd <= rx_xtd;
        h_rtr <= rx_rtr;
        h_dlc <= rx_dlc;
        scan_run <= 1'b1;
        scan_idx <= 5'h0;
        hit <= 1'b0;
        rx_pend <= 1'b0;
      end else if (scan_run) begin
        if (obj_match(scan_idx)) begin
          hit <= 1'b1;
          hit_obj <= scan_idx;
          scan_run <= 1'b0;
        end else if (scan_idx == `LAST_OBJ) begin
          scan_run <= 1'b0;
        end else begin
          scan_idx <= scan_idx + 5'h1;
        end
      end
      if (rx_ok && !init_hold) begin
        h_data <= rx_data;
        rx_pend <= 1'b1;
      end else if (rx_pend && !scan_run && (!hit || rx_apply)) begin
        rx_pend <= 1'b0;
      end

      case (state)
        ST_IDLE: begin
          if (transfer_in_progress_flag[0]) begin
            cur <= 1'b0;
            state <= ST_IF_RD;
          end else if (transfer_in_progress_flag[1]) begin
            cur <= 1'b1;
            state <= ST_IF_RD;
          end
        end
        ST_IF_RD: begin
          // Write: fetch unselected parts; read: fetch selected parts
          if (cm[`CM_ARB] != wdir)
            if_arb[cur] <= {object_valid_flag[on], mo_arb[on]};
          if (cm[`CM_MSK] != wdir)
            if_msk[cur] <= {1'b0, mo_msk[on]};
          if (cm[`CM_CTL] != wdir)
            if_ctl[cur] <= {16'h0, new_data_flag[on], mo_ctl[on][`CT_ML],
              interrupt_pending_flag[on], mo_ctl[on][12:9], transmit_request_flag[on],
              mo_ctl[on][7:0]};
          if (cm[`CM_DA] != wdir)
            if_da[cur] <= mo_da[on];
          if (cm[`CM_DB] != wdir)
            if_db[cur] <= mo_db[on];
          if (wdir) begin
            state <= ST_IF_WR;
          end else begin
            if (cm[`CM_ND])
              new_data_flag[on] <= 1'b0;
            if (cm[`CM_CIP])
              interrupt_pending_flag[on] <= 1'b0;
            transfer_in_progress_flag[cur] <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_IF_WR: begin
          object_valid_flag[on] <= if_arb[cur][`AR_VAL];
          new_data_flag[on] <= if_ctl[cur][`CT_ND] | cm[`CM_ND];
          transmit_request_flag[on] <= if_ctl[cur][`CT_TR] | cm[`CM_ND];
          interrupt_pending_flag[on] <= if_ctl[cur][`CT_IP] & ~cm[`CM_CIP];
          transfer_in_progress_flag[cur] <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase

      if (rx_apply) begin
        if (!h_rtr) begin
          new_data_flag[hit_obj] <= 1'b1;
          transmit_request_flag[hit_obj] <= 1'b0;
          if (mo_ctl[hit_obj][`CT_RXIE])
            interrupt_pending_flag[hit_obj] <= 1'b1;
        end else if (hit_dir && hit_rmt) begin
          transmit_request_flag[hit_obj] <= 1'b1;
        end else if (hit_dir && hit_um) begin
          transmit_request_flag[hit_obj] <= 1'b0;
          new_data_flag[hit_obj] <= 1'b1;
        end
        // Otherwise the remote frame is dropped
      end

      if (tx_start) begin
        tx_load <= 1'b1;
        tx_obj <= tx_pick[4:0];
        tx_active <= 1'b1;
        tx_id <= mo_arb[tx_pick[4:0]][28:0];
        tx_xtd <= mo_arb[tx_pick[4:0]][`AR_XTD];
        tx_rtr <= !mo_arb[tx_pick[4:0]][`AR_DIR];
        tx_dlc <= mo_ctl[tx_pick[4:0]][3:0];
        tx_data <= {mo_db[tx_pick[4:0]], mo_da[tx_pick[4:0]]};
        if (no_auto_retransmit_bit)
          transmit_request_flag[tx_pick[4:0]] <= 1'b0;
        else
          new_data_flag[tx_pick[4:0]] <= 1'b0;
      end

      // Completion events last so their sets win over same-cycle clears
      if (tx_active && core_tx_ok) begin
        tx_active <= 1'b0;
        if (no_auto_retransmit_bit)
          new_data_flag[tx_obj] <= 1'b0;
        else if (!new_data_flag[tx_obj])
          transmit_request_flag[tx_obj] <= 1'b0;
        if (mo_ctl[tx_obj][`CT_TXIE])
          interrupt_pending_flag[tx_obj] <= 1'b1;
      end else if (tx_active && core_tx_fail) begin
        // Request stays set unless no_auto_retransmit_bit cleared it at load; the next pick re-ranks all pending objects
        tx_active <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/can_msg_regs.vh
`ifndef CAN_MSG_REGS_VH
`define CAN_MSG_REGS_VH

`define A_CTRL 8'h00
`define A_TXRQ 8'h01
`define A_NEWDAT 8'h02
`define A_INTERRUPT_PENDING_FLAG 8'h03
`define A_VALID 8'h04
`define A_INTID 8'h05
`define IF0_HI 4'h1
`define IF1_HI 4'h2
`define O_CMASK 4'h0
`define O_CREQ 4'h1
`define O_ARB 4'h2
`define O_MSK 4'h3
`define O_CTL 4'h4
`define O_DA 4'h5
`define O_DB 4'h6

`define CR_INIT 0
`define CR_DAR 1
`define CQ_BUSY 15
`define CQ_MAXNUM 6'h20

`define CM_WR 7
`define CM_MSK 6
`define CM_ARB 5
`define CM_CTL 4
`define CM_CIP 3
`define CM_ND 2
`define CM_DA 1
`define CM_DB 0

`define AR_VAL 31
`define AR_DIR 30
`define AR_XTD 29
`define MK_MDIR 30
`define MK_MXTD 29

`define CT_ND 15
`define CT_ML 14
`define CT_IP 13
`define CT_UM 12
`define CT_TXIE 11
`define CT_RXIE 10
`define CT_RMT 9
`define CT_TR 8
`define CT_EOB 7

`define STD_ID_MASK 29'h1ffc0000
`define ALL_ID_MASK 29'h1fffffff
`define NONE_FOUND 6'h20
`define LAST_OBJ 5'h1f

`endif

// file: tb/can_core_model.sv
`timescale 1ns/1ps
module can_core_model (
  input wire clk,
  input wire rst_n,
  input wire tx_load,
  input wire [28:0] tx_id,
  output reg core_tx_ready,
  output reg core_tx_ok,
  output reg core_tx_fail,
  output reg rx_hdr,
  output reg [28:0] rx_id,
  output reg rx_xtd,
  output reg rx_rtr,
  output reg [3:0] rx_dlc,
  output reg rx_ok,
  output reg [63:0] rx_data
);
  logic [28:0] sent [$];
  int fails;
  int wait_cnt;
  initial begin
    {rx_hdr, rx_ok, rx_xtd, rx_rtr} = 4'h0;
    rx_id = 29'h0;
    rx_dlc = 4'h0;
    rx_data = 64'h0;
    fails = 0;
  end
  // Bus time is a fixed few cycles; a commanded failure loses arbitration once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_tx_ready <= 1'b1;
      core_tx_ok <= 1'b0;
      core_tx_fail <= 1'b0;
      wait_cnt <= 0;
    end else begin
      core_tx_ok <= 1'b0;
      core_tx_fail <= 1'b0;
      if (tx_load) begin
        sent.push_back(tx_id);
        core_tx_ready <= 1'b0;
        wait_cnt <= 6;
      end else if (wait_cnt == 1) begin
        core_tx_ready <= 1'b1;
        core_tx_ok <= (fails == 0);
        core_tx_fail <= (fails != 0);
        if (fails != 0) fails = fails - 1;
        wait_cnt <= 0;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
  // ID and DLC lines are only held with the header pulse, data only with the end pulse
  task automatic send(input logic [28:0] id, input logic rtr, input logic [3:0] dlc,
                      input logic [63:0] d);
    @(posedge clk);
    rx_id <= id;
    rx_rtr <= rtr;
    rx_dlc <= dlc;
    rx_hdr <= 1'b1;
    @(posedge clk);
    rx_hdr <= 1'b0;
    rx_id <= ~id;
    rx_dlc <= ~dlc;
    repeat (40) @(posedge clk);
    rx_data <= d;
    rx_ok <= 1'b1;
    @(posedge clk);
    rx_ok <= 1'b0;
    rx_data <= ~d;
  endtask
endmodule

// file: tb/can_message_object_handler_asserts.sv
`timescale 1ns/1ps
module can_message_object_handler_asserts (
  input wire clk,
  input wire rst_n,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire init_hold,
  input wire [1:0] transfer_in_progress_flag,
  input wire core_tx_ready,
  input wire tx_load,
  input wire core_tx_ok,
  input wire core_tx_fail
);
  reg pend;
  // Frame on the wire, from its load until the core reports an outcome
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
    end else if (tx_load) begin
      pend <= 1'b1;
    end else if (core_tx_ok || core_tx_fail) begin
      pend <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cmd_sets_busy: assert property (wr && addr == 8'h11 && wdata >= 32'h1 &&
    wdata <= 32'h20 && !transfer_in_progress_flag[0] |=> transfer_in_progress_flag[0])
    else $error("busy not set by command");
  a_cmd_zero_ignored: assert property (wr && addr == 8'h11 && wdata == 32'h0 &&
    !transfer_in_progress_flag[0] |=> !transfer_in_progress_flag[0])
    else $error("object zero started a transfer");
  a_busy_ends_soon: assert property ($rose(transfer_in_progress_flag[0]) |->
    ##[1:6] !transfer_in_progress_flag[0])
    else $error("transfer did not complete");
  a_busy_has_cause: assert property ($rose(transfer_in_progress_flag[1]) |->
    $past(wr) && $past(addr) == 8'h21)
    else $error("busy without command");
  a_load_cause: assert property (tx_load |-> $past(core_tx_ready) &&
    $past(transfer_in_progress_flag) == 2'b00)
    else $error("load while core busy or transfer active");
  a_init_blocks_tx: assert property (init_hold |=> !tx_load)
    else $error("load during init");
  a_single_frame: assert property (tx_load |-> !pend)
    else $error("second frame before outcome");
  a_init_stable: assert property (!(wr && addr == 8'h00) |=> $stable(init_hold))
    else $error("init bit changed without write");
endmodule

bind can_message_object_handler can_message_object_handler_asserts u_asserts (
  .clk(clk),
  .rst_n(rst_n),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .init_hold(init_hold),
  .transfer_in_progress_flag(transfer_in_progress_flag),
  .core_tx_ready(core_tx_ready),
  .tx_load(tx_load),
  .core_tx_ok(core_tx_ok),
  .core_tx_fail(core_tx_fail)
);

// file: tb/can_message_object_handler_test.sv
`timescale 1ns/1ps
module can_message_object_handler_test;
  logic clk;
  logic rst_n;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  wire [31:0] rdata;
  wire init_hold;
  wire [1:0] transfer_in_progress_flag;
  wire core_tx_ready, tx_load, tx_xtd, tx_rtr, core_tx_ok, core_tx_fail;
  wire rx_hdr, rx_xtd, rx_rtr, rx_ok;
  wire [28:0] tx_id, rx_id;
  wire [3:0] tx_dlc, rx_dlc;
  wire [63:0] tx_data, rx_data;
  int mismatches = 0;
  int total_checks = 0;

  can_message_object_handler u_can_message_object_handler (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .init_hold(init_hold),
    .transfer_in_progress_flag(transfer_in_progress_flag), .core_tx_ready(core_tx_ready),
    .tx_load(tx_load), .tx_id(tx_id), .tx_xtd(tx_xtd), .tx_rtr(tx_rtr), .tx_dlc(tx_dlc),
    .tx_data(tx_data), .core_tx_ok(core_tx_ok), .core_tx_fail(core_tx_fail),
    .rx_hdr(rx_hdr), .rx_id(rx_id), .rx_xtd(rx_xtd), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc),
    .rx_ok(rx_ok), .rx_data(rx_data));
  can_core_model u_can_core_model (.clk(clk), .rst_n(rst_n), .tx_load(tx_load),
    .tx_id(tx_id), .core_tx_ready(core_tx_ready), .core_tx_ok(core_tx_ok),
    .core_tx_fail(core_tx_fail), .rx_hdr(rx_hdr), .rx_id(rx_id), .rx_xtd(rx_xtd),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_ok(rx_ok), .rx_data(rx_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata & m, exp);
  endtask
  task automatic cmd(input logic [7:0] base, input logic [7:0] m, input logic [5:0] n);
    int k;
    put(base, {24'h0, m});
    put(base + 8'h01, {26'h0, n});
    #1 check({31'h0, transfer_in_progress_flag[base[5]]}, 32'h1);
    for (k = 0; k < 20 && transfer_in_progress_flag[base[5]] !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    check({31'h0, transfer_in_progress_flag[base[5]]}, 32'h0);
  endtask
  function automatic logic [31:0] arb(input logic d, input logic [10:0] id);
    return {1'b1, d, 1'b0, id, 18'h0};
  endfunction
  task automatic cfg(input logic [5:0] n, input logic d, input logic [10:0] id,
                     input logic [15:0] c);
    put(8'h12, arb(d, id));
    put(8'h13, 32'h0);
    put(8'h14, {16'h0, c});
    put(8'h15, {21'h0, id});
    put(8'h16, 32'h0);
    cmd(8'h10, 8'hf3, n);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    end_sim;
  end

  initial begin
    {rst_n, wr, rd, addr, wdata} = 43'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1 check({31'h0, init_hold}, 32'h1);
    get(8'h07, 32'h0, 32'hffffffff);
    cfg(6'h1, 1'b1, 11'h100, 16'h0888);
    cfg(6'h2, 1'b1, 11'h200, 16'h0888);
    cfg(6'h3, 1'b0, 11'h055, 16'h0488);
    cfg(6'h4, 1'b1, 11'h066, 16'h0288);
    // Partial write: stale arbitration in the buffer must come back from the object
    put(8'h12, 32'h0);
    put(8'h15, 32'hcafe0000);
    cmd(8'h10, 8'h82, 6'h2);
    get(8'h12, arb(1'b1, 11'h200), 32'hffffffff);
    put(8'h26, 32'hdead0001);
    cmd(8'h20, 8'h02, 6'h2);
    get(8'h25, 32'hcafe0000, 32'hffffffff);
    get(8'h26, 32'hdead0001, 32'hffffffff);
    put(8'h11, 32'h0);
    #1 check({31'h0, transfer_in_progress_flag[0]}, 32'h0);
    // Two requests pending at once, the lower-numbered one goes first and loses arbitration once
    u_can_core_model.fails = 1;
    cmd(8'h10, 8'h84, 6'h2);
    cmd(8'h10, 8'h84, 6'h1);
    put(8'h00, 32'h0);
    repeat (80) @(posedge clk);
    check(u_can_core_model.sent.size(), 32'h3);
    check({3'h0, u_can_core_model.sent[0]}, {14'h0100, 18'h0});
    check({3'h0, u_can_core_model.sent[1]}, {14'h0100, 18'h0});
    check({3'h0, u_can_core_model.sent[2]}, {14'h0200, 18'h0});
    check(tx_data[31:0], 32'hcafe0000);
    check(tx_data[63:32], 32'h0);
    check({26'h0, tx_xtd, tx_rtr, tx_dlc}, 32'h8);
    get(8'h02, 32'h0, 32'h3);
    get(8'h05, 32'h1, 32'hffffffff);
    cmd(8'h20, 8'h10, 6'h2);
    get(8'h24, 32'h2888, 32'hffff);
    cmd(8'h20, 8'h08, 6'h1);
    cmd(8'h20, 8'h08, 6'h2);
    get(8'h05, 32'h0, 32'hffffffff);
    u_can_core_model.send({11'h055, 18'h0}, 1'b0, 4'h4, 64'h8877665544332211);
    repeat (4) @(posedge clk);
    get(8'h05, 32'h3, 32'hffffffff);
    cmd(8'h20, 8'h33, 6'h3);
    get(8'h21, 32'h3, 32'hffff);
    get(8'h24, 32'ha484, 32'hffff);
    get(8'h25, 32'h44332211, 32'hffffffff);
    get(8'h22, arb(1'b0, 11'h055), 32'hffffffff);
    u_can_core_model.send({11'h055, 18'h0}, 1'b0, 4'h4, 64'h0);
    repeat (4) @(posedge clk);
    cmd(8'h20, 8'h10, 6'h3);
    get(8'h24, 32'he484, 32'hffff);
    u_can_core_model.send({11'h066, 18'h0}, 1'b1, 4'h0, 64'h0);
    repeat (60) @(posedge clk);
    check(u_can_core_model.sent.size(), 32'h4);
    check({3'h0, u_can_core_model.sent[3]}, {14'h0066, 18'h0});
    check(tx_data[31:0], 32'h66);
    // Remote frame for a plain transmit object is dropped; then one failure, no retry
    u_can_core_model.send({11'h100, 18'h0}, 1'b1, 4'h0, 64'h0);
    repeat (10) @(posedge clk);
    put(8'h00, 32'h2);
    u_can_core_model.fails = 1;
    cmd(8'h10, 8'h84, 6'h2);
    repeat (20) @(posedge clk);
    check(u_can_core_model.sent.size(), 32'h5);
    check({3'h0, u_can_core_model.sent[4]}, {14'h0200, 18'h0});
    get(8'h01, 32'h0, 32'h1);
    get(8'h01, 32'h0, 32'h2);
    get(8'h02, 32'h2, 32'h2);
    // Reset in mid-run keeps the message RAM, loses the four flags, the control bits and the interface buffers
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 check({31'h0, init_hold}, 32'h1);
    get(8'h02, 32'h0, 32'hffffffff);
    cmd(8'h20, 8'h30, 6'h3);
    get(8'h22, arb(1'b0, 11'h055) & 32'h7fffffff, 32'hffffffff);
    get(8'h24, 32'h4484, 32'hffff);
    end_sim;
  end
endmodule
